// ---- iobc_defs.vh ----
// constants for the internal oscillator block control
//
// Overview of operation
// R1: fast source at 8 MHz drives clock directly or through postscaler.
// R2: fast source enabled whenever selected frequency is 125 kHz to 8 MHz.
// R3: slow RC runs when selected or any watchdog-type feature is enabled.
// R4: frequency select field picks fast direct, slow direct or postscaled fast.
// R5: select 111 is 8 MHz, 110..001 halve down to 125 kHz, 000 is 31 kHz.
// R6: clock-out mode drives system clock over four on second pin, first is I/O.
// R7: dual I/O mode uses both oscillator pins as port A bits 7 and 6.
// R8: slow RC runs independently of the fast source.
// R9: fast source slews to new trim within 1 ms, no completion flag.
// R10: trim value changes only the fast source frequency.
// R11: at 31 kHz, select bit 1 uses fast over 256, 0 uses slow RC.
// R12: slow RC always clocks watchdog and fail-safe monitor.
// R13: four-times multiplier gives up to 32 MHz when enabled.
// R14: multiplier enabled by software through bit 6 of tuning register.
// R15: multiplier allowed only in internal oscillator modes 1001 or 1000.
// R16: multiplier works only with 8 MHz or 4 MHz selected.
// R17: where multiplier unavailable its enable bit is forced and reads zero.
// R18: tuning register bit 5 reads zero, writes ignored.
// R19: trim is signed: 00000 calibrated, 01111 maximum, 10000 minimum.
// R20: decrementing trim lowers fast frequency, incrementing raises it.
// R21: tuning register clears to zero on reset.
`ifndef IOBC_DEFS_VH
`define IOBC_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define IOBC_ADDR_TUNE     3'h0
`define IOBC_ADDR_CTRL     3'h1
`define IOBC_ADDR_PORT_LAT 3'h2
`define IOBC_ADDR_PORT_DIR 3'h3
`define IOBC_ADDR_PORT_PIN 3'h4
`define IOBC_ADDR_STATUS   3'h5

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define IOBC_TUNE_LFSRC_BIT 7
`define IOBC_TUNE_MULT_BIT  6
`define IOBC_TUNE_RSVD_BIT  5
`define IOBC_TUNE_RST       8'h00
`define IOBC_CTRL_FSEL_RST  3'h4
`define IOBC_PORT_LAT_RST   2'h0
`define IOBC_PORT_DIR_RST   2'h3
`define IOBC_FSEL_8M        3'h7
`define IOBC_FSEL_4M        3'h6
`define IOBC_FSEL_31K       3'h0
`define IOBC_MODE_CLKOUT    4'h9
`define IOBC_MODE_DUALIO    4'h8

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define IOBC_MCLK_KHZ       200000
`define IOBC_MCLK_PERIOD_PS 5000
`define IOBC_FAST_KHZ       8000
`define IOBC_SLOW_KHZ       31
`define IOBC_ACC_SCALE      64'd16777216
`define IOBC_FAST_INC       ((`IOBC_FAST_KHZ * `IOBC_ACC_SCALE) / `IOBC_MCLK_KHZ)
`define IOBC_SLOW_INC       ((`IOBC_SLOW_KHZ * `IOBC_ACC_SCALE) / `IOBC_MCLK_KHZ)
`define IOBC_TRIM_STEP      (`IOBC_FAST_INC / 256)
`define IOBC_SETTLE_NS      1000000
`define IOBC_SETTLE_CYC     ((`IOBC_SETTLE_NS * 1000) / `IOBC_MCLK_PERIOD_PS)
`define IOBC_SLEW_CYC       (`IOBC_SETTLE_CYC / 32)

`endif

// ---- iobc_sync.v ----
// two-stage synchroniser for pin and strap levels
`timescale 1ns/1ps
module iobc_sync #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         reset,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  // ------------------------------------------------------------
  // first stage feeds only the second
  // ------------------------------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule

// ---- iobc_postscaler.v ----
// postscaler dividing fast source ticks by powers of two
`timescale 1ns/1ps
`include "iobc_defs.vh"
module iobc_postscaler (
  input  wire       mclk,
  input  wire       reset,
  input  wire       in_tick,
  input  wire [2:0] fsel,
  output reg        out_tick
);
  reg  [7:0] div_cnt_r;
  reg  [7:0] mask;

  // ------------------------------------------------------------
  // divisor: 111 direct, each step halves, 000 over 256
  // ------------------------------------------------------------
  always @* begin
    if (fsel == `IOBC_FSEL_31K)
      mask = 8'hFF;                      // [R11]
    else
      mask = 8'h7F >> fsel;              // [R5]
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_cnt_r <= 8'h00;
      out_tick  <= 1'b0;
    end else begin
      if (in_tick)
        div_cnt_r <= div_cnt_r + 8'h01;
      out_tick <= in_tick && ((div_cnt_r & mask) == mask);   // [R1]
    end
  end
endmodule

// ---- iobc_ctrl.v ----
// internal oscillator block control: sources, postscaler, multiplier, trim, pins
`timescale 1ns/1ps
`include "iobc_defs.vh"
module iobc_ctrl #(
  parameter SLEW_CYC = `IOBC_SLEW_CYC
) (
  input  wire       mclk,
  input  wire       reset,
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire [3:0] osc_mode_cfg,
  input  wire       pwrt_en,
  input  wire       fscm_en,
  input  wire       wdt_en,
  input  wire       two_speed_en,
  input  wire       osc_pin_first_in,
  output reg        osc_pin_first_out,
  output reg        osc_pin_first_oe_n,
  input  wire       osc_pin_second_in,
  output reg        osc_pin_second_out,
  output reg        osc_pin_second_oe_n,
  output wire       fast_src_en,
  output wire       slow_src_en,
  output wire       mult_active,
  output reg        fast_tick,
  output reg        slow_tick,
  output reg        sys_tick,
  output wire       wdt_tick
);

  // ------------------------------------------------------------
  // constants
  // ------------------------------------------------------------
  // wide constant arithmetic cut to accumulator width on purpose
  localparam [63:0] FAST_INC_W  = `IOBC_FAST_INC;
  localparam [63:0] SLOW_INC_W  = `IOBC_SLOW_INC;
  localparam [63:0] TRIM_STEP_W = `IOBC_TRIM_STEP;
  localparam [31:0] SLEW_M1     = SLEW_CYC - 1;
  localparam [23:0] FAST_INC = FAST_INC_W[23:0];
  localparam [23:0] SLOW_INC = SLOW_INC_W[23:0];
  localparam signed [24:0] TRIM_STEP = TRIM_STEP_W[24:0];
  localparam [23:0] SLEW_MAX = SLEW_M1[23:0];

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function is_int_mode;
    input [3:0] mode;
    begin
      is_int_mode = (mode == `IOBC_MODE_CLKOUT) ||
                    (mode == `IOBC_MODE_DUALIO);
    end
  endfunction

  function is_high_sel;
    input [2:0] sel;
    begin
      is_high_sel = (sel == `IOBC_FSEL_8M) || (sel == `IOBC_FSEL_4M);
    end
  endfunction

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  wire [7:0] cfg_s;
  wire [1:0] pin_s;
  wire [3:0] mode_s;
  wire       feat_any;

  iobc_sync #(
    .W (8)
  ) u_cfg_sync (
    .mclk  (mclk),
    .reset (reset),
    .d     ({osc_mode_cfg, pwrt_en, fscm_en, wdt_en, two_speed_en}),
    .q     (cfg_s)
  );

  iobc_sync #(
    .W (2)
  ) u_pin_sync (
    .mclk  (mclk),
    .reset (reset),
    .d     ({osc_pin_first_in, osc_pin_second_in}),
    .q     (pin_s)
  );

  assign mode_s   = cfg_s[7:4];
  assign feat_any = |cfg_s[3:0];

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  reg  [7:0] tune_r;
  reg  [7:0] tune_nxt;
  reg  [2:0] fsel_r;
  reg  [1:0] lat_r;
  reg  [1:0] dir_r;
  wire       mult_allow;
  wire       lfsrc;
  wire       wr_tune;

  assign mult_allow = is_int_mode(mode_s);                    // [R15]
  assign lfsrc      = tune_r[`IOBC_TUNE_LFSRC_BIT];
  assign wr_tune    = reg_wr && (reg_addr == `IOBC_ADDR_TUNE);

  // bit 5 never stored; enable cleared whenever mode disallows it
  always @* begin
    tune_nxt = tune_r;
    if (wr_tune) begin
      tune_nxt = reg_wdata;                                   // [R14]
      tune_nxt[`IOBC_TUNE_RSVD_BIT] = 1'b0;                   // [R18]
    end
    if (!mult_allow)
      tune_nxt[`IOBC_TUNE_MULT_BIT] = 1'b0;                   // [R17]
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      tune_r <= `IOBC_TUNE_RST;                               // [R21]
      fsel_r <= `IOBC_CTRL_FSEL_RST;
      lat_r  <= `IOBC_PORT_LAT_RST;
      dir_r  <= `IOBC_PORT_DIR_RST;
    end else begin
      tune_r <= tune_nxt;
      if (reg_wr && (reg_addr == `IOBC_ADDR_CTRL))
        fsel_r <= reg_wdata[2:0];                             // [R4]
      if (reg_wr && (reg_addr == `IOBC_ADDR_PORT_LAT))
        lat_r <= reg_wdata[7:6];
      if (reg_wr && (reg_addr == `IOBC_ADDR_PORT_DIR))
        dir_r <= reg_wdata[7:6];
    end
  end

  // ------------------------------------------------------------
  // read port, data valid only in the cycle after the strobe
  // ------------------------------------------------------------
  reg [7:0] rd_mux;

  always @* begin
    case (reg_addr)
      `IOBC_ADDR_TUNE:     rd_mux = tune_r;                   // [R17]
      `IOBC_ADDR_CTRL:     rd_mux = {5'h00, fsel_r};
      `IOBC_ADDR_PORT_LAT: rd_mux = {lat_r, 6'h00};
      `IOBC_ADDR_PORT_DIR: rd_mux = {dir_r, 6'h00};
      `IOBC_ADDR_PORT_PIN: rd_mux = {pin_s, 6'h00};
      `IOBC_ADDR_STATUS:   rd_mux = {4'h0, mult_active, fast_src_en,
                                     slow_src_en, mult_allow};
      default:             rd_mux = 8'h00;
    endcase
  end

  always @(posedge mclk or posedge reset) begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 8'h00;
  end

  // ------------------------------------------------------------
  // source enables
  // ------------------------------------------------------------
  wire sel_31k;

  assign sel_31k = (fsel_r == `IOBC_FSEL_31K);
  // fast source also kept on when it feeds the 31 kHz choice
  assign fast_src_en = !sel_31k || lfsrc;                     // [R2] [R11]
  assign slow_src_en = (sel_31k && !lfsrc) || feat_any;       // [R3]
  assign mult_active = mult_allow && tune_r[`IOBC_TUNE_MULT_BIT] &&
                       is_high_sel(fsel_r);                   // [R16]

  // ------------------------------------------------------------
  // trim slew: one code step per interval, full swing in 1 ms
  // ------------------------------------------------------------
  reg  [4:0]  trim_cur_r;
  reg  [23:0] slew_cnt_r;
  wire [4:0]  trim_tgt;
  wire        slew_due;

  assign trim_tgt = tune_r[4:0];
  assign slew_due = (slew_cnt_r == SLEW_MAX);

  // no done flag by design; software simply waits out the settle time
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      trim_cur_r <= 5'h00;
      slew_cnt_r <= 24'h000000;
    end else begin
      slew_cnt_r <= slew_due ? 24'h000000 : slew_cnt_r + 24'h000001;
      if (slew_due) begin
        if ($signed(trim_cur_r) < $signed(trim_tgt))
          trim_cur_r <= trim_cur_r + 5'h01;                   // [R9]
        else if ($signed(trim_cur_r) > $signed(trim_tgt))
          trim_cur_r <= trim_cur_r - 5'h01;                   // [R9]
      end
    end
  end

  // ------------------------------------------------------------
  // fast source phase accumulator, signed trim offset
  // ------------------------------------------------------------
  wire signed [24:0] trim_off;
  wire [23:0]        fast_inc;
  wire [24:0]        fast_sum;
  reg  [23:0]        fast_acc_r;

  assign trim_off = $signed(trim_cur_r) * TRIM_STEP;          // [R19]
  assign fast_inc = FAST_INC + trim_off[23:0];                // [R20]
  assign fast_sum = {1'b0, fast_acc_r} + {1'b0, fast_inc};

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      fast_acc_r <= 24'h000000;
      fast_tick  <= 1'b0;
    end else if (fast_src_en) begin
      fast_acc_r <= fast_sum[23:0];
      fast_tick  <= fast_sum[24];                             // [R1]
    end else begin
      fast_acc_r <= 24'h000000;
      fast_tick  <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // slow RC accumulator: fixed rate, trim never reaches it
  // ------------------------------------------------------------
  reg  [23:0] slow_acc_r;
  wire [24:0] slow_sum;

  assign slow_sum = {1'b0, slow_acc_r} + {1'b0, SLOW_INC};    // [R8] [R10]

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      slow_acc_r <= 24'h000000;
      slow_tick  <= 1'b0;
    end else if (slow_src_en) begin
      slow_acc_r <= slow_sum[23:0];
      slow_tick  <= slow_sum[24];
    end else begin
      slow_acc_r <= 24'h000000;
      slow_tick  <= 1'b0;
    end
  end

  // watchdog side ignores the low-frequency select
  assign wdt_tick = slow_tick;                                // [R12]

  // ------------------------------------------------------------
  // multiplier: four times the selected 8 or 4 MHz
  // ------------------------------------------------------------
  reg  [23:0] mult_acc_r;
  wire [23:0] mult_inc;
  wire [24:0] mult_sum;
  reg         mult_tick_r;

  // 8 MHz times four is 32 MHz; 4 MHz times four is 16 MHz
  assign mult_inc = (fsel_r == `IOBC_FSEL_8M) ? {fast_inc[21:0], 2'b00}
                                              : {fast_inc[22:0], 1'b0};
  assign mult_sum = {1'b0, mult_acc_r} + {1'b0, mult_inc};

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      mult_acc_r  <= 24'h000000;
      mult_tick_r <= 1'b0;
    end else if (mult_active) begin
      mult_acc_r  <= mult_sum[23:0];                          // [R13]
      mult_tick_r <= mult_sum[24];
    end else begin
      mult_acc_r  <= 24'h000000;
      mult_tick_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // postscaler and output selection
  // ------------------------------------------------------------
  wire post_tick;
  reg  sys_nxt;

  iobc_postscaler u_post (
    .mclk     (mclk),
    .reset    (reset),
    .in_tick  (fast_tick),
    .fsel     (fsel_r),
    .out_tick (post_tick)
  );

  // postscaler adds one cycle of latency; acceptable for a tick stream
  always @* begin
    case (fsel_r)
      `IOBC_FSEL_8M:  sys_nxt = mult_active ? mult_tick_r : post_tick;
      `IOBC_FSEL_4M:  sys_nxt = mult_active ? mult_tick_r : post_tick;
      `IOBC_FSEL_31K: sys_nxt = lfsrc ? post_tick : slow_tick; // [R11]
      default:        sys_nxt = post_tick;                    // [R5]
    endcase
  end

  always @(posedge mclk or posedge reset) begin
    if (reset)
      sys_tick <= 1'b0;
    else
      sys_tick <= sys_nxt;                                    // [R4]
  end

  // ------------------------------------------------------------
  // clock output at system rate over four
  // ------------------------------------------------------------
  reg [1:0] q_cnt_r;

  always @(posedge mclk or posedge reset) begin
    if (reset)
      q_cnt_r <= 2'h0;
    else if (sys_tick)
      q_cnt_r <= q_cnt_r + 2'h1;                              // [R6]
  end

  // ------------------------------------------------------------
  // oscillator pin reuse
  // ------------------------------------------------------------
  wire clkout_mode;
  wire dualio_mode;

  assign clkout_mode = (mode_s == `IOBC_MODE_CLKOUT);
  assign dualio_mode = (mode_s == `IOBC_MODE_DUALIO);

  // outside the internal modes the pins belong to other oscillator logic
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      osc_pin_first_out   <= 1'b0;
      osc_pin_first_oe_n  <= 1'b1;
      osc_pin_second_out  <= 1'b0;
      osc_pin_second_oe_n <= 1'b1;
    end else begin
      osc_pin_first_out  <= lat_r[1];
      osc_pin_first_oe_n <= !(is_int_mode(mode_s) && !dir_r[1]); // [R6] [R7]
      if (clkout_mode) begin
        osc_pin_second_out  <= q_cnt_r[1];                    // [R6]
        osc_pin_second_oe_n <= 1'b0;
      end else if (dualio_mode) begin
        osc_pin_second_out  <= lat_r[0];                      // [R7]
        osc_pin_second_oe_n <= dir_r[0];
      end else begin
        osc_pin_second_out  <= 1'b0;
        osc_pin_second_oe_n <= 1'b1;
      end
    end
  end

endmodule

// ---- iobc_ctrl_props.sv ----
// assertions on the oscillator block control ports
`timescale 1ns/1ps
module iobc_ctrl_props #(
  parameter SLEW_CYC = 4
) (
  input wire       mclk,
  input wire       reset,
  input wire [2:0] reg_addr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire [3:0] osc_mode_cfg,
  input wire       osc_pin_first_oe_n,
  input wire       osc_pin_second_oe_n,
  input wire       fast_src_en,
  input wire       mult_active,
  input wire       fast_tick,
  input wire       slow_tick,
  input wire       wdt_tick
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ------------------------------------------------------------
  // helpers: cycles the strap has held, covers the two sync flops
  // ------------------------------------------------------------
  wire       mode_int = (osc_mode_cfg == 4'h9) || (osc_mode_cfg == 4'h8);
  reg  [2:0] bad_r;
  reg  [2:0] clk_r;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      bad_r <= 3'h0;
      clk_r <= 3'h0;
    end else begin
      bad_r <= mode_int ? 3'h0 : ((bad_r == 3'h7) ? bad_r : bad_r + 3'h1);
      clk_r <= (osc_mode_cfg != 4'h9) ? 3'h0 : ((clk_r == 3'h7) ? clk_r : clk_r + 3'h1);
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_rsvd_bit;
    $past(reg_rd) && ($past(reg_addr) == 3'h0) |-> !reg_rdata[5];
  endproperty
  a_rsvd_bit: assert property (p_rsvd_bit) else $error("tune bit 5 read back set");
  property p_mult_rd;
    $past(reg_rd) && ($past(reg_addr) == 3'h0) && (bad_r == 3'h7) |-> !reg_rdata[6];
  endproperty
  a_mult_rd: assert property (p_mult_rd) else $error("multiplier bit reads set");
  property p_mult_mode;
    (bad_r >= 3'h4) |-> !mult_active;
  endproperty
  a_mult_mode: assert property (p_mult_mode) else $error("multiplier on in wrong mode");
  property p_mult_fsel;
    mult_active |-> fast_src_en;
  endproperty
  a_mult_fsel: assert property (p_mult_fsel) else $error("multiplier on without fast source");
  property p_wdt;
    wdt_tick == slow_tick;
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog tick not from slow source");
  property p_oe_idle;
    (bad_r == 3'h7) |-> osc_pin_first_oe_n && osc_pin_second_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("pin driven outside internal modes");
  property p_clkout_oe;
    (clk_r == 3'h7) |-> !osc_pin_second_oe_n;
  endproperty
  a_clkout_oe: assert property (p_clkout_oe) else $error("clock out pin not driven");
  property p_fast_pulse;
    fast_tick |=> !fast_tick;
  endproperty
  a_fast_pulse: assert property (p_fast_pulse) else $error("fast tick too long");
  property p_slow_gap;
    slow_tick |=> !slow_tick [*8];
  endproperty
  a_slow_gap: assert property (p_slow_gap) else $error("slow ticks too close");
  c_mult: cover property (mult_active);
  c_clkout: cover property (clk_r == 3'h7);
  c_read: cover property ($past(reg_rd) && (reg_rdata != 8'h00));
endmodule
bind iobc_ctrl iobc_ctrl_props #(.SLEW_CYC(SLEW_CYC)) i_props (
  .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .osc_mode_cfg(osc_mode_cfg),
  .osc_pin_first_oe_n(osc_pin_first_oe_n), .osc_pin_second_oe_n(osc_pin_second_oe_n),
  .fast_src_en(fast_src_en), .mult_active(mult_active), .fast_tick(fast_tick),
  .slow_tick(slow_tick), .wdt_tick(wdt_tick));

// ---- iobc_ctrl_tb.sv ----
// self-checking bench for the oscillator block control
`timescale 1ns/1ps
`include "iobc_defs.vh"
module iobc_ctrl_tb;
  reg        mclk, reset, reg_wr, reg_rd, pin1_in, pin2_in, p2;
  reg  [2:0] reg_addr;
  reg  [7:0] reg_wdata, rv;
  reg  [3:0] osc_mode_cfg, feat;
  reg [31:0] lfsr;
  wire [7:0] reg_rdata;
  wire       out1, oe1, out2, oe2, fast_en, slow_en, mult_on;
  wire       fast_tick, slow_tick, sys_tick, wdt_tick;
  integer    failures, samples_checked, fc, sc, sl, pr, fh, slh, i;
  iobc_ctrl #(.SLEW_CYC(4)) i_dut (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_mode_cfg(osc_mode_cfg),
    .pwrt_en(feat[0]), .fscm_en(feat[1]), .wdt_en(feat[2]), .two_speed_en(feat[3]),
    .osc_pin_first_in(pin1_in), .osc_pin_first_out(out1), .osc_pin_first_oe_n(oe1),
    .osc_pin_second_in(pin2_in), .osc_pin_second_out(out2), .osc_pin_second_oe_n(oe2),
    .fast_src_en(fast_en), .slow_src_en(slow_en), .mult_active(mult_on),
    .fast_tick(fast_tick), .slow_tick(slow_tick), .sys_tick(sys_tick), .wdt_tick(wdt_tick));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  task chk(input [8*8-1:0] nm, input [7:0] e, input [7:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task chk_near(input [8*8-1:0] nm, input integer e, input integer g, input integer t);
    begin
      samples_checked = samples_checked + 1;
      if ((g > e + t) || (g < e - t) || ((^g) === 1'bx) || ((^e) === 1'bx)) begin
        failures = failures + 1;
        $display("mismatch %0s expected %0d seen %0d", nm, e, g);
      end
    end
  endtask
  // read data stand only in the cycle after the strobe
  task chk_rd(input [8*8-1:0] nm, input [2:0] a, input [7:0] e);
    begin
      @(posedge mclk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(nm, e, reg_rdata);
    end
  endtask
  task cnt(input integer n);
    begin
      fc = 0; sc = 0; sl = 0; pr = 0; p2 = out2;
      repeat (n) begin
        @(posedge mclk); #1;
        fc = fc + fast_tick; sc = sc + sys_tick; sl = sl + slow_tick;
        pr = pr + (out2 && !p2); p2 = out2;
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // ------------------------------------------------------------
  // clock, watchdog on the run
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #480000;
    failures = failures + 1;
    report_and_stop;
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    failures = 0; samples_checked = 0; lfsr = 32'd70731;
    reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 3'h0; reg_wdata = 8'h00;
    osc_mode_cfg = 4'h0; feat = 4'h0; pin1_in = 1'b0; pin2_in = 1'b0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    idle(2);
    chk_rd("tune", `IOBC_ADDR_TUNE, 8'h00);
    chk_rd("ctrl", `IOBC_ADDR_CTRL, 8'h04);
    chk_rd("dir", `IOBC_ADDR_PORT_DIR, 8'hC0);
    chk_rd("unmap", 3'h6, 8'h00);
    $display("test reset done");
    for (i = 1; i < 8; i = i + 1) begin
      wr(`IOBC_ADDR_CTRL, i[7:0]);
      cnt(4096);
      chk_near("post", fc >> (7 - i), sc, 2);
      chk("fast_en", 8'h01, {7'h0, fast_en});
    end
    // 31 kHz from the fast source over 256, then from the slow source
    wr(`IOBC_ADDR_TUNE, 8'h80);
    wr(`IOBC_ADDR_CTRL, 8'h00);
    cnt(12288);
    chk("fast_en", 8'h01, {7'h0, fast_en});
    chk_near("div256", fc / 256, sc, 1);
    wr(`IOBC_ADDR_TUNE, 8'h00);
    cnt(12288);
    chk_near("slowsel", sl, sc, 1);
    chk("slow_en", 8'h01, {7'h0, slow_en});
    wr(`IOBC_ADDR_CTRL, 8'h07);
    for (i = 0; i < 4; i = i + 1) begin
      feat <= 4'h1 << i;
      idle(4);
      chk("feat", 8'h01, {7'h0, slow_en});
    end
    $display("test frequency select done");
    // extreme trims, waits cover the shortened slew
    wr(`IOBC_ADDR_TUNE, 8'h0F);
    idle(200);
    cnt(8192);
    fh = fc; slh = sl;
    wr(`IOBC_ADDR_TUNE, 8'h10);
    idle(200);
    cnt(8192);
    chk("trim", 8'h01, {7'h0, fh > fc + 20});
    chk_near("slowtrim", slh, sl, 1);
    feat <= 4'h0;
    $display("test trim done");
    osc_mode_cfg <= 4'h9;
    idle(8);
    for (i = 0; i < 8; i = i + 1) begin
      lfsr = lfsr_next(lfsr);
      wr(`IOBC_ADDR_TUNE, lfsr[7:0]);
      chk_rd("tune", `IOBC_ADDR_TUNE, lfsr[7:0] & 8'hDF);
      wr(`IOBC_ADDR_CTRL, {5'h0, lfsr[10:8]});
      chk_rd("ctrl", `IOBC_ADDR_CTRL, {5'h0, lfsr[10:8]});
    end
    wr(`IOBC_ADDR_TUNE, 8'h40);
    wr(`IOBC_ADDR_CTRL, 8'h07);
    idle(4);
    chk("mult", 8'h01, {7'h0, mult_on});
    chk_rd("status", `IOBC_ADDR_STATUS, 8'h0D);
    cnt(4096);
    chk_near("x4", 4 * fc, sc, 4);
    wr(`IOBC_ADDR_CTRL, 8'h06);
    idle(4);
    cnt(4096);
    chk_near("x4half", 2 * fc, sc, 4);
    wr(`IOBC_ADDR_CTRL, 8'h05);
    idle(4);
    chk("mult", 8'h00, {7'h0, mult_on});
    $display("test multiplier done");
    wr(`IOBC_ADDR_CTRL, 8'h07);
    wr(`IOBC_ADDR_PORT_LAT, 8'h80);
    wr(`IOBC_ADDR_PORT_DIR, 8'h00);
    idle(4);
    chk("pins", 8'h02, {6'h0, out1, oe1 | oe2});
    cnt(4096);
    chk_near("clkout", sc / 4, pr, 1);
    osc_mode_cfg <= 4'h8;
    idle(8);
    chk_rd("tune", `IOBC_ADDR_TUNE, 8'h40);
    wr(`IOBC_ADDR_PORT_LAT, 8'h40);
    idle(4);
    chk("dualio", 8'h04, {5'h0, out2, out1, oe1 | oe2});
    wr(`IOBC_ADDR_PORT_DIR, 8'hC0);
    lfsr = lfsr_next(lfsr);
    pin1_in <= lfsr[0];
    pin2_in <= lfsr[1];
    idle(4);
    chk("oe_in", 8'h03, {6'h0, oe1, oe2});
    chk_rd("pin_rd", `IOBC_ADDR_PORT_PIN, {lfsr[0], lfsr[1], 6'h0});
    osc_mode_cfg <= 4'h0;
    idle(8);
    chk_rd("tune", `IOBC_ADDR_TUNE, 8'h00);
    chk("nomode", 8'h01, {6'h0, mult_on, oe2});
    $display("test pins done");
    wr(`IOBC_ADDR_TUNE, 8'h9F);
    reset <= 1'b1;
    idle(2);
    reset <= 1'b0;
    idle(2);
    chk_rd("tune", `IOBC_ADDR_TUNE, 8'h00);
    $display("test second reset done");
    report_and_stop;
  end
endmodule
